/* shared/ers_defines.svh */
// Register map, field positions, reset values and bus widths of the receive
// signaling block. Assumes inclusion by the package and the design only.
`ifndef ERS_DEFINES_SVH
`define ERS_DEFINES_SVH

// =============================================================================
// Register indices (byte address is four times the index)
`define ERS_CTRL_IDX      11'h3A0
`define ERS_SUBST_IDX     11'h3C0
`define ERS_ARRAY_IDX     11'h500
`define ERS_GLOB_IDX      11'h4E0
`define ERS_IDX_W         11
`define ERS_ADDR_W        13
`define ERS_NUM_TS        32

// =============================================================================
// Control register fields
`define ERS_CTRL_SUB_EN   6
`define ERS_CTRL_OH_EN    5
`define ERS_CTRL_DEB_EN   4
`define ERS_CTRL_SUB_HI   3
`define ERS_CTRL_SUB_LO   2
`define ERS_CTRL_EXT_HI   1
`define ERS_CTRL_EXT_LO   0
`define ERS_CTRL_MASK     8'h7F
`define ERS_CTRL_RESET    8'h00

// =============================================================================
// Substitution register fields
`define ERS_SUB_TWO_A     6
`define ERS_SUB_FOUR_B    5
`define ERS_SUB_FOUR_A    4
`define ERS_SUB_MASK      8'h7F
`define ERS_SUB_RESET     8'h00

// =============================================================================
// Format codes, signaling values and global control
`define ERS_FMT_ALL_ONES  2'b00
`define ERS_FMT_SIXTEEN   2'b01
`define ERS_FMT_FOUR      2'b10
`define ERS_FMT_TWO       2'b11
`define ERS_EXT_NONE      2'b00
`define ERS_ABCD_ONES     4'hF
`define ERS_ABCD_RESET    4'h0
`define ERS_GLOB_SIG_EN   0
`define ERS_GLOB_RESET    8'h00

`endif

/* shared/ers_pkg.sv */
// Types shared by the receive signaling block and its surroundings.
// Assumes the defines header is on the include path.
`include "ers_defines.svh"

package ers_pkg;

    // Receive PCM word of one timeslot with its ABCD nibble, A in bit 3.
    typedef struct packed {
        logic       valid;
        logic [4:0] ts;
        logic [7:0] octet;
        logic [3:0] abcd;
    } ers_pcm_s;

    // Signaling of one timeslot, A in bit 3.
    typedef struct packed {
        logic       valid;
        logic [4:0] ts;
        logic [3:0] abcd;
    } ers_sig_s;

    typedef enum logic [2:0] {
        ERS_REG_NONE,
        ERS_REG_CTRL,
        ERS_REG_SUBST,
        ERS_REG_ARRAY,
        ERS_REG_GLOB
    } ers_region_e;

endpackage

/* src/ers_rx_sig.sv */
// Receive CAS signaling extraction and substitution for one E1 channel.
// Assumes a single 50 MHz clock, one stream word per cycle at most, and an
// Avalon-MM master that holds its request until waitrequest is low.
//
// Summary of operation
// - Control bits 3:2 choose the signaling substitution format per timeslot.
// - Format 00 with substitution active forces every signaling bit to one.
// - Format 01 replaces A, B, C, D from substitution bits 0-3.
// - Format 10 replaces A and B from substitution bits 4 and 5.
// - Format 11 replaces A from substitution bit 6.
// - Control bits 1:0 choose the signaling extraction format per timeslot.
// - Extraction format 00 extracts nothing from the timeslot.
// - Extraction format 01 extracts all of A, B, C and D.
// - Extraction format 10 extracts only A and B.
// - Extraction format 11 extracts only A.
// - Extracted signaling feeds the array, signaling pin and overhead output.
// - Thirty-two substitution registers, lowest address timeslot 0, highest 31.
// - Substitution bit 6 replaces A under two-code substitution.
// - Bit 5 replaces B and bit 4 replaces A under four-code substitution.
// - Bits 3, 2, 1, 0 replace D, C, B, A under sixteen-code substitution.
// - Substitution only when enable bit 6 set, touching only outgoing PCM.
// - With overhead enable set, array contents appear on the overhead output.
// - Each read-only array register holds the latest ABCD in bits 3-0.
`timescale 1ns/100ps
`include "ers_defines.svh"

module ers_rx_sig
(
    input  wire logic                     core_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic [`ERS_ADDR_W-1:0]   avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [31:0]              avs_readdata_o,
    output logic                          avs_waitrequest_o,
    input  wire ers_pkg::ers_pcm_s        pcm_i,
    input  wire ers_pkg::ers_sig_s        sig_i,
    output ers_pkg::ers_pcm_s             pcm_o,
    output ers_pkg::ers_sig_s             sig_o,
    output ers_pkg::ers_sig_s             oh_o
);
    import ers_pkg::*;

    // =========================================================================
    // Helpers
    // Control, substitution and array regions are 32 words aligned to 32, so the upper index bits pick them; global is one word matched whole.
    function automatic ers_region_e decode(input logic [`ERS_IDX_W-1:0] idx);
        if (idx[10:5] == 6'(`ERS_CTRL_IDX >> 5))
            return ERS_REG_CTRL;
        else if (idx[10:5] == 6'(`ERS_SUBST_IDX >> 5))
            return ERS_REG_SUBST;
        else if (idx[10:5] == 6'(`ERS_ARRAY_IDX >> 5))
            return ERS_REG_ARRAY;
        else if (idx == `ERS_GLOB_IDX)
            return ERS_REG_GLOB;
        else
            return ERS_REG_NONE;
    endfunction

    // Nibble order is A in bit 3 down to D in bit 0.
    // Positions that a format does not replace keep the received bit.
    function automatic logic [3:0] substitute(input logic [1:0] fmt, input logic [7:0] val,
                                              input logic [3:0] rx);
        unique case (fmt)
            `ERS_FMT_ALL_ONES: return `ERS_ABCD_ONES;
            `ERS_FMT_SIXTEEN:  return {val[0], val[1], val[2], val[3]};
            `ERS_FMT_FOUR:     return {val[`ERS_SUB_FOUR_A], val[`ERS_SUB_FOUR_B], rx[1:0]};
            `ERS_FMT_TWO:      return {val[`ERS_SUB_TWO_A], rx[2:0]};
        endcase
    endfunction

    // Bits not taken keep their last value, so a narrower format never clears C and D.
    function automatic logic [3:0] extract(input logic [1:0] fmt, input logic [3:0] old,
                                           input logic [3:0] rx);
        unique case (fmt)
            `ERS_EXT_NONE: return old;
            2'b01:         return rx;
            2'b10:         return {rx[3:2], old[1:0]};
            2'b11:         return {rx[3], old[2:0]};
        endcase
    endfunction

    // =========================================================================
    // Register bus: one wait cycle, then the answer.
    // The fixed wait lets read data come from a flip-flop before it is shown,
    // at the cost of one extra cycle on every access.
    logic                    ack_q, ack_d;
    logic [31:0]             rdata_q, rdata_d;
    logic [`ERS_IDX_W-1:0]   idx;
    ers_region_e             region;
    logic                    req, wr_now;

    assign idx    = avs_address_i[`ERS_ADDR_W-1:2];
    assign region = decode(idx);
    assign req    = avs_read_i | avs_write_i;
    assign wr_now = avs_write_i & ack_q & avs_byteenable_i[0];
    assign avs_waitrequest_o = req & ~ack_q;
    assign avs_readdata_o    = rdata_q;

    // =========================================================================
    // Register arrays
    logic [7:0] ctrl_q  [`ERS_NUM_TS];
    logic [7:0] ctrl_d  [`ERS_NUM_TS];
    logic [7:0] subst_q [`ERS_NUM_TS];
    logic [7:0] subst_d [`ERS_NUM_TS];
    logic [3:0] arr_q   [`ERS_NUM_TS];
    logic [3:0] arr_d   [`ERS_NUM_TS];
    logic [7:0] glob_q, glob_d;

    always_comb
    begin
        ack_d   = req & ~ack_q;
        rdata_d = rdata_q;
        glob_d  = glob_q;
        ctrl_d  = ctrl_q;
        subst_d = subst_q;
        arr_d   = arr_q;
        // Read data is captured on the waiting cycle so it stands at the ack edge.
        if (avs_read_i && !ack_q)
        begin
            unique case (region)
                ERS_REG_CTRL:  rdata_d = {24'h000000, ctrl_q[idx[4:0]]};
                // timeslot taken from the low index bits
                ERS_REG_SUBST: rdata_d = {24'h000000, subst_q[idx[4:0]]};
                // array value in bits 3-0, upper bits read zero
                ERS_REG_ARRAY: rdata_d = {28'h0000000, arr_q[idx[4:0]]};
                ERS_REG_GLOB:  rdata_d = {24'h000000, glob_q};
                ERS_REG_NONE:  rdata_d = 32'h00000000;
            endcase
        end
        // Writes land on the answer edge, when waitrequest is low.
        if (wr_now)
        begin
            unique case (region)
                ERS_REG_CTRL:  ctrl_d[idx[4:0]]  = avs_writedata_i[7:0] & `ERS_CTRL_MASK;
                ERS_REG_SUBST: subst_d[idx[4:0]] = avs_writedata_i[7:0] & `ERS_SUB_MASK;
                ERS_REG_GLOB:  glob_d            = {7'h00, avs_writedata_i[`ERS_GLOB_SIG_EN]};
                default:       ;
            endcase
        end
        // extracted signaling lands in the array
        if (sig_i.valid)
            arr_d[sig_i.ts] = extract(ctrl_q[sig_i.ts][`ERS_CTRL_EXT_HI:`ERS_CTRL_EXT_LO],
                                      arr_q[sig_i.ts], sig_i.abcd);
    end

    // everything clears on reset
    // The array clears too, so a read before any signaling returns zero.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
            glob_q  <= `ERS_GLOB_RESET;
            for (int i = 0; i < `ERS_NUM_TS; i++)
            begin
                ctrl_q[i]  <= `ERS_CTRL_RESET;
                subst_q[i] <= `ERS_SUB_RESET;
                arr_q[i]   <= `ERS_ABCD_RESET;
            end
        end
        else
        begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            glob_q  <= glob_d;
            ctrl_q  <= ctrl_d;
            subst_q <= subst_d;
            arr_q   <= arr_d;
        end
    end

    // =========================================================================
    // Stream outputs, one cycle behind the PCM input.
    ers_pcm_s pcm_q, pcm_d;
    ers_sig_s sig_q, sig_d;
    ers_sig_s oh_q, oh_d;
    logic [7:0] cur_ctrl;

    // A register write at the same edge as a word takes effect from the next word on.
    assign cur_ctrl = ctrl_q[pcm_i.ts];

    always_comb
    begin
        pcm_d = pcm_i;
        // only the outgoing PCM is altered, and only when enabled
        if (pcm_i.valid && cur_ctrl[`ERS_CTRL_SUB_EN])
            pcm_d.abcd = substitute(cur_ctrl[`ERS_CTRL_SUB_HI:`ERS_CTRL_SUB_LO],
                                    subst_q[pcm_i.ts], pcm_i.abcd);
        // signaling pin follows the array when the interface is enabled
        sig_d.valid = pcm_i.valid & glob_q[`ERS_GLOB_SIG_EN];
        sig_d.ts    = pcm_i.ts;
        sig_d.abcd  = arr_q[pcm_i.ts];
        // overhead output carries the array when enabled for the timeslot
        oh_d.valid  = pcm_i.valid & cur_ctrl[`ERS_CTRL_OH_EN];
        oh_d.ts     = pcm_i.ts;
        oh_d.abcd   = arr_q[pcm_i.ts];
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pcm_q <= '0;
            sig_q <= '0;
            oh_q  <= '0;
        end
        else
        begin
            pcm_q <= pcm_d;
            sig_q <= sig_d;
            oh_q  <= oh_d;
        end
    end

    assign pcm_o = pcm_q;
    assign sig_o = sig_q;
    assign oh_o  = oh_q;

    // =========================================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    // Control and substitution words of the timeslot on the PCM input.
    logic [7:0] c_now;
    logic [7:0] s_now;
    assign c_now = ctrl_q[pcm_i.ts];
    assign s_now = subst_q[pcm_i.ts];

    a_bus_one_wait: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("Bus answer not given after one wait cycle.");
    a_subst_lands: assert property (wr_now && region == ERS_REG_SUBST
        |=> subst_q[$past(idx[4:0])] == ($past(avs_writedata_i[7:0]) & 8'h7F))
        else $error("Substitution register write did not land.");

    // =========================================================================
    // Checks: substitution
    a_sub_all_ones: assert property (pcm_i.valid && c_now[6] && c_now[3:2] == 2'b00
        |=> pcm_o.valid && pcm_o.abcd == 4'hF)
        else $error("All-ones substitution missing.");
    a_sub_sixteen: assert property (pcm_i.valid && c_now[6] && c_now[3:2] == 2'b01
        |=> pcm_o.abcd == {$past(s_now[0]), $past(s_now[1]), $past(s_now[2]), $past(s_now[3])})
        else $error("Sixteen-code substitution wrong.");
    a_sub_four: assert property (pcm_i.valid && c_now[6] && c_now[3:2] == 2'b10
        |=> pcm_o.abcd == {$past(s_now[4]), $past(s_now[5]), $past(pcm_i.abcd[1:0])})
        else $error("Four-code substitution wrong.");
    a_sub_two: assert property (pcm_i.valid && c_now[6] && c_now[3:2] == 2'b11
        |=> pcm_o.abcd == {$past(s_now[6]), $past(pcm_i.abcd[2:0])})
        else $error("Two-code substitution wrong.");
    a_sub_disabled: assert property (!c_now[6] |=> pcm_o == $past(pcm_i))
        else $error("PCM altered with substitution off.");
    a_sub_octet_kept: assert property (pcm_i.valid |=> pcm_o.valid && pcm_o.octet == $past(pcm_i.octet))
        else $error("PCM octet or valid not passed through.");
    a_sub_array_kept: assert property (pcm_i.valid && c_now[6] && !sig_i.valid
        |=> arr_q[$past(pcm_i.ts)] == $past(arr_q[pcm_i.ts]))
        else $error("Substitution disturbed the signaling array.");

    // =========================================================================
    // Checks: extraction and outputs
    a_extract_none: assert property (sig_i.valid && ctrl_q[sig_i.ts][1:0] == 2'b00
        |=> arr_q[$past(sig_i.ts)] == $past(arr_q[sig_i.ts]))
        else $error("Array changed with extraction off.");
    a_extract_full: assert property (sig_i.valid && ctrl_q[sig_i.ts][1:0] == 2'b01
        |=> arr_q[$past(sig_i.ts)] == $past(sig_i.abcd))
        else $error("Full extraction wrong.");
    a_extract_ab: assert property (sig_i.valid && ctrl_q[sig_i.ts][1:0] == 2'b10
        |=> arr_q[$past(sig_i.ts)] == {$past(sig_i.abcd[3:2]), $past(arr_q[sig_i.ts][1:0])})
        else $error("A and B extraction wrong.");
    a_extract_a: assert property (sig_i.valid && ctrl_q[sig_i.ts][1:0] == 2'b11
        |=> arr_q[$past(sig_i.ts)] == {$past(sig_i.abcd[3]), $past(arr_q[sig_i.ts][2:0])})
        else $error("A-only extraction wrong.");
    a_oh_gate: assert property (pcm_i.valid |=> oh_o.valid == $past(c_now[5]))
        else $error("Overhead output not gated by its enable.");
    a_oh_content: assert property (pcm_i.valid && c_now[5] |=> oh_o.abcd == $past(arr_q[pcm_i.ts]))
        else $error("Overhead output does not carry the array.");
    a_sig_gate: assert property (pcm_i.valid |=> sig_o.valid == $past(glob_q[0]))
        else $error("Signaling pin not gated by the interface enable.");
    a_sig_content: assert property (pcm_i.valid && glob_q[0] |=> sig_o.abcd == $past(arr_q[pcm_i.ts]))
        else $error("Signaling pin does not carry the array.");

    // =========================================================================
    // Coverage
    c_sub_four:  cover property (pcm_i.valid && c_now[6] && c_now[3:2] == 2'b10);
    c_sub_two:   cover property (pcm_i.valid && c_now[6] && c_now[3:2] == 2'b11);
    c_ext_ab:    cover property (sig_i.valid && ctrl_q[sig_i.ts][1:0] == 2'b10);
    c_oh_out:    cover property (oh_o.valid && sig_o.valid);
    c_bus_write: cover property (wr_now && region == ERS_REG_SUBST);

endmodule // ers_rx_sig

/* testbench/ers_rx_sig_test.sv */
// Self-checking bench of the receive signaling block.
// Assumes the sink model and an Avalon-MM master with one request at a time.
`timescale 1ns/100ps

module ers_rx_sig_test;
    import ers_pkg::*;

    logic        core_clk_i      = 1'b0;
    logic        resetn_i        = 1'b0;
    logic [12:0] avs_address_i   = 13'h0000;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    ers_pcm_s    pcm_i           = '0;
    ers_sig_s    sig_i           = '0;
    ers_pcm_s    pcm_o;
    ers_sig_s    sig_o;
    ers_sig_s    oh_o;
    ers_pcm_s    k_pcm;
    ers_sig_s    k_sig;
    ers_sig_s    k_oh;
    logic [7:0]  k_sc;
    logic [7:0]  k_oc;
    int          miscompares     = 0;
    int          checks_done     = 0;

    always #10 core_clk_i = ~core_clk_i;

    ers_rx_sig i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .pcm_i(pcm_i), .sig_i(sig_i), .pcm_o(pcm_o), .sig_o(sig_o), .oh_o(oh_o));

    ers_sink i_sink (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .pcm_i(pcm_o), .sig_i(sig_o),
        .oh_i(oh_o), .pcm_o(k_pcm), .sig_o(k_sig), .oh_o(k_oh), .sig_cnt_o(k_sc), .oh_cnt_o(k_oc));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The request stands until the edge at which waitrequest is seen low; read data are taken there.
    task automatic bus(input logic wr, input logic [12:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        @(posedge core_clk_i);
        while (avs_waitrequest_o !== 1'b0)
        begin
            n++;
            @(posedge core_clk_i);
        end
        // Every access answers after exactly one wait cycle.
        check(n, 32'd1);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask

    function automatic logic [12:0] ctl(input int n);
        return 13'h0E80 + 13'(4 * n);
    endfunction

    function automatic logic [12:0] sub(input int n);
        return 13'h0F00 + 13'(4 * n);
    endfunction

    function automatic logic [12:0] arr(input int n);
        return 13'h1400 + 13'(4 * n);
    endfunction

    task automatic pcm(input logic [4:0] ts, input logic [3:0] ab);
        @(posedge core_clk_i);
        pcm_i <= '{1'b1, ts, 8'hC3, ab};
        @(posedge core_clk_i);
        pcm_i <= '0;
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic sig(input logic [4:0] ts, input logic [3:0] ab);
        @(posedge core_clk_i);
        sig_i <= '{1'b1, ts, ab};
        @(posedge core_clk_i);
        sig_i <= '0;
    endtask

    task automatic t_reset();
        rd_chk(ctl(0), 32'h0);
        rd_chk(sub(31), 32'h0);
        rd_chk(arr(7), 32'h0);
        rd_chk(13'h0000, 32'h0);
    endtask

    task automatic t_regs();
        wr(sub(0), 8'hFF);
        wr(sub(31), 8'h75);
        wr(arr(7), 8'h0F);
        rd_chk(sub(0), 32'h7F);
        rd_chk(sub(31), 32'h75);
        rd_chk(arr(7), 32'h0);
    endtask

    // Substitution value 0x75 against received 0x1 separates every format.
    task automatic t_subst();
        logic [3:0] exp [4];
        exp = '{4'hF, 4'hA, 4'hD, 4'h9};
        for (int f = 0; f < 4; f++)
        begin
            wr(ctl(31), 8'h40 | 8'(f << 2));
            pcm(5'd31, 4'h1);
            check(k_pcm.abcd, exp[f]);
            check({k_pcm.ts, k_pcm.octet}, {5'd31, 8'hC3});
        end
        wr(ctl(31), 8'h04);
        pcm(5'd31, 4'h1);
        check(k_pcm.abcd, 4'h1);
    endtask

    task automatic t_extract();
        logic [3:0] din [4];
        logic [3:0] exp [4];
        din = '{4'hF, 4'h0, 4'hF, 4'h0};
        exp = '{4'hF, 4'h3, 4'hB, 4'hB};
        for (int i = 0; i < 4; i++)
        begin
            wr(ctl(2), 8'((i + 1) % 4));
            sig(5'd2, din[i]);
            rd_chk(arr(2), {28'h0, exp[i]});
        end
        wr(ctl(2), 8'h40);
        pcm(5'd2, 4'h5);
        check(k_pcm.abcd, 4'hF);
        rd_chk(arr(2), 32'hB);
    endtask

    task automatic t_outputs();
        logic [7:0] sc;
        logic [7:0] oc;
        wr(13'h1380, 8'h01);
        wr(ctl(2), 8'h20);
        pcm(5'd2, 4'h0);
        check({k_sig.ts, k_sig.abcd, k_oh.ts, k_oh.abcd}, {5'd2, 4'hB, 5'd2, 4'hB});
        sc = k_sc;
        oc = k_oc;
        wr(13'h1380, 8'h00);
        wr(ctl(2), 8'h00);
        pcm(5'd2, 4'h0);
        check({k_sc, k_oc}, {sc, oc});
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_regs();
        t_subst();
        t_extract();
        t_outputs();
        wrap_up();
    end
endmodule // ers_rx_sig_test

/* testbench/ers_sink.sv */
// Backplane sink model: keeps the last PCM, signaling pin and overhead words.
// Assumes the block's registered stream outputs on one clock.
`timescale 1ns/100ps

module ers_sink
(
    input  wire logic              core_clk_i,
    input  wire logic              resetn_i,
    input  wire ers_pkg::ers_pcm_s pcm_i,
    input  wire ers_pkg::ers_sig_s sig_i,
    input  wire ers_pkg::ers_sig_s oh_i,
    output ers_pkg::ers_pcm_s      pcm_o,
    output ers_pkg::ers_sig_s      sig_o,
    output ers_pkg::ers_sig_s      oh_o,
    output logic [7:0]             sig_cnt_o,
    output logic [7:0]             oh_cnt_o
);
    import ers_pkg::*;

    // The backplane never stalls, so a word is taken in its only cycle.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pcm_o     <= '0;
            sig_o     <= '0;
            oh_o      <= '0;
            sig_cnt_o <= 8'h00;
            oh_cnt_o  <= 8'h00;
        end
        else
        begin
            if (pcm_i.valid) pcm_o <= pcm_i;
            if (sig_i.valid) sig_o <= sig_i;
            if (sig_i.valid) sig_cnt_o <= sig_cnt_o + 8'h01;
            if (oh_i.valid) oh_o <= oh_i;
            if (oh_i.valid) oh_cnt_o <= oh_cnt_o + 8'h01;
        end
    end
endmodule // ers_sink
